// >>> adc_cal_asserts.sv
/*
 * concurrent checks on the adc calibration control ports.
 * assumes the single clk_sys_i domain and asynchronous arst_n_i reset.
 */
`timescale 1ns/10ps
module adc_cal_asserts
    import adc_cal_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int CH_IDX_W = 1
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // watched inputs
    input wire logic mode_wr_i,
    input wire logic [2:0] mode_i,
    input wire logic coeff_wr_i,
    input wire logic [CH_IDX_W-1:0] coeff_ch_i,
    input wire logic coeff_gain_sel_i,
    input wire logic [OFF_W-1:0] coeff_data_i,
    input wire logic [NUM_CH-1:0] ready_clr_i,
    // watched outputs
    input wire logic filter_restart_o,
    input wire logic adc_hold_reset_o,
    input wire logic adc_power_down_o,
    input wire logic [1:0] input_sel_o,
    input wire logic cal_busy_o,
    input wire logic [NUM_CH-1:0] ready_o,
    input wire logic [NUM_CH*OFF_W-1:0] offset_coeff_o,
    input wire logic [NUM_CH*GAIN_W-1:0] gain_coeff_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_start;
        mode_wr_i && mode_i != MODE_PDN && mode_i != MODE_IDLE;
    endsequence
    sequence s_cal_req;
        mode_wr_i && mode_i[2];
    endsequence
    // a write just before the end legitimately moves the coefficient
    sequence s_cal_end;
        $fell(cal_busy_o) && !$past(mode_wr_i) && !$past(coeff_wr_i);
    endsequence

    a_restart_on_write: assert property (s_start |=> filter_restart_o)
        else $error("no filter restart after mode write");
    a_idle_no_restart: assert property (mode_wr_i && mode_i == MODE_IDLE
        |=> !filter_restart_o && adc_hold_reset_o)
        else $error("idle write misbehaved");
    a_cal_busy_start: assert property (s_cal_req |=> cal_busy_o)
        else $error("calibration not started");
    a_self_zero_sel: assert property (mode_wr_i && (mode_i == MODE_SELF_OFF
        || mode_i == MODE_SELF_GAIN) |=> input_sel_o == SEL_ZERO)
        else $error("self calibration not on internal zero");
    a_system_pin_sel: assert property (mode_wr_i && (mode_i == MODE_SYS_ZERO
        || mode_i == MODE_SYS_FULL) |=> input_sel_o == SEL_PINS)
        else $error("system calibration not on pins");
    a_cal_end_idle: assert property (s_cal_end |-> adc_hold_reset_o && !adc_power_down_o)
        else $error("not idle after calibration");
    a_coeff_kept: assert property (s_cal_end |-> $stable(offset_coeff_o)
        && $stable(gain_coeff_o))
        else $error("calibration changed a coefficient register");
    a_pdn_power: assert property (mode_wr_i && mode_i == MODE_PDN
        |=> adc_power_down_o && !cal_busy_o)
        else $error("power down not entered");
    a_offset_write: assert property (coeff_wr_i && !coeff_gain_sel_i && coeff_ch_i == 0
        |=> offset_coeff_o[OFF_W-1:0] == $past(coeff_data_i))
        else $error("offset coefficient write lost");
    a_ready_sticky: assert property (ready_o[0] && !ready_clr_i[0] |=> ready_o[0])
        else $error("ready dropped without clear");
endmodule

bind adc_calibration_control adc_cal_asserts #(.NUM_CH(NUM_CH), .CH_IDX_W(CH_IDX_W)) u_chk (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .mode_wr_i(mode_wr_i), .mode_i(mode_i),
    .coeff_wr_i(coeff_wr_i), .coeff_ch_i(coeff_ch_i), .coeff_gain_sel_i(coeff_gain_sel_i),
    .coeff_data_i(coeff_data_i), .ready_clr_i(ready_clr_i),
    .filter_restart_o(filter_restart_o), .adc_hold_reset_o(adc_hold_reset_o),
    .adc_power_down_o(adc_power_down_o), .input_sel_o(input_sel_o), .cal_busy_o(cal_busy_o),
    .ready_o(ready_o), .offset_coeff_o(offset_coeff_o), .gain_coeff_o(gain_coeff_o));

// >>> adc_cal_pkg.sv
/*
 * constants for the adc calibration control block: mode codes, coefficient
 * formats, correction arithmetic constants and sequencer states.
 * assumes a single clock domain and a decimation filter that delivers one
 * signed result word per channel with a shared valid strobe.
 */
package adc_cal_pkg;

    // operating mode field codes
    localparam logic [2:0] MODE_PDN = 3'h0;
    localparam logic [2:0] MODE_CONT = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_IDLE = 3'h3;
    localparam logic [2:0] MODE_SELF_OFF = 3'h4;
    localparam logic [2:0] MODE_SELF_GAIN = 3'h5;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
    localparam logic [2:0] MODE_SYS_FULL = 3'h7;

    // data formats
    localparam int RAW_W = 32;
    localparam int OFF_W = 24;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 14;
    localparam int OFF_ALIGN_SHIFT = 10;
    localparam int OFFCAL_SHIFT = 7;

    // coefficient nominal and saturation values
    localparam logic [OFF_W-1:0] OFF_NOM = 24'h00_0000;
    localparam logic [GAIN_W-1:0] GAIN_NOM = 16'h5555;
    localparam logic [GAIN_W-1:0] GAIN_SAT = 16'hFFFF;

    // 4/3 in 1.15 fixed point, together with the shift giving 4/3 * 2^9/2^4
    localparam logic [16:0] FOUR_THIRDS = 17'h0_AAAB;

    // result clamp limits
    localparam logic [RAW_W-1:0] POS_LIM = 32'h0FFF_FFFF;
    localparam logic [RAW_W-1:0] NEG_LIM = 32'hF000_0000;

    // analog input selection
    localparam logic [1:0] SEL_PINS = 2'h0;
    localparam logic [1:0] SEL_ZERO = 2'h1;
    localparam logic [1:0] SEL_REF = 2'h2;

    // sequencer states
    typedef enum logic [5:0] {
        ST_PDN = 6'h01,
        ST_IDLE = 6'h02,
        ST_CONV = 6'h04,
        ST_CAL1 = 6'h08,
        ST_CAL2 = 6'h10,
        ST_DIV = 6'h20
    } cal_state_type;

endpackage

// >>> adc_calibration_control.sv
/*
 * calibration sequencer and offset/gain correction datapath for the
 * sigma-delta adc channels, with per-channel coefficient storage.
 * assumes the decimation filter restarts on filter_restart_o, then raises
 * filter_valid_i once per settled result for all channels together, and
 * that software keeps the coefficient update window and calibration limits.
 */
// Operation
// - writing mode field starts the operation
// - mode 4: self offset, internal zero
// - offset calibration runs like single conversion
// - offset coefficient goes to result, not offset
// - mode 5: two-stage self gain calibration
// - gain coefficient goes to channel result
// - mode 6: zero-scale on input pins
// - mode 7: full-scale on input pins
// - calibration end returns adc to idle
// - reset reloads factory offset and gain
// - subtract signed 24-bit offset coefficient
// - scale by gain over two^14
// - clamp overflow, then format unipolar/twos
// - align offset by two^9 over two^4
// - offset coefficient scaled by four thirds
// - factory gain suits amplifier gain eight
// - calibration request aborts running conversion
// - mode 2 single, mode 1 continuous
`timescale 1ns/10ps
module adc_calibration_control
    import adc_cal_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int CH_IDX_W = 1,
    parameter logic [NUM_CH*OFF_W-1:0] FACTORY_OFF = {NUM_CH{OFF_NOM}},
    parameter logic [NUM_CH*GAIN_W-1:0] FACTORY_GAIN = {NUM_CH{GAIN_NOM}}
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // mode control
    input wire logic mode_wr_i,
    input wire logic [2:0] mode_i,
    input wire logic [NUM_CH-1:0] chan_en_i,
    input wire logic unipolar_i,
    // decimation filter
    input wire logic filter_valid_i,
    input wire logic [NUM_CH*RAW_W-1:0] filter_data_i,
    // coefficient writes
    input wire logic coeff_wr_i,
    input wire logic [CH_IDX_W-1:0] coeff_ch_i,
    input wire logic coeff_gain_sel_i,
    input wire logic [OFF_W-1:0] coeff_data_i,
    // status acknowledge
    input wire logic [NUM_CH-1:0] ready_clr_i,
    // analog control
    output logic filter_restart_o,
    output logic adc_hold_reset_o,
    output logic adc_power_down_o,
    output logic [1:0] input_sel_o,
    output logic cal_busy_o,
    // results and status
    output logic [NUM_CH*RAW_W-1:0] result_o,
    output logic [NUM_CH-1:0] ready_o,
    output logic [NUM_CH-1:0] over_range_o,
    output logic [NUM_CH-1:0] under_range_o,
    output logic [NUM_CH*OFF_W-1:0] offset_coeff_o,
    output logic [NUM_CH*GAIN_W-1:0] gain_coeff_o
);

    localparam int WIDE_W = RAW_W + GAIN_W + 3;
    localparam int CORR_W = WIDE_W - GAIN_FRAC;
    // divider walks the quotient from its top bit down to bit zero
    localparam logic [3:0] DIV_TOP = 4'(GAIN_W - 1);
    // target full-scale code shifted into the gain fraction
    localparam logic [WIDE_W-1:0] GAIN_NUMER = {5'h00, POS_LIM, 14'h0000};

    if (NUM_CH < 1 || NUM_CH > (1 << CH_IDX_W))
    begin : g_bad_ch
        $error("NUM_CH does not fit CH_IDX_W");
    end

    cal_state_type state;
    logic [2:0] cur_mode;
    logic [3:0] div_bit;
    logic wr_conv;
    logic wr_offcal;
    logic cap_zero;
    logic ld_div;
    logic wr_gain;
    logic run_req;

    // sample handling; a mode write in the same cycle wins and drops the sample
    always_comb
    begin
        wr_conv = filter_valid_i && !mode_wr_i && state == ST_CONV;
        wr_offcal = filter_valid_i && !mode_wr_i && state == ST_CAL1 &&
                    (cur_mode == MODE_SELF_OFF || cur_mode == MODE_SYS_ZERO);
        cap_zero = filter_valid_i && !mode_wr_i && state == ST_CAL1 &&
                   cur_mode == MODE_SELF_GAIN;
        ld_div = filter_valid_i && !mode_wr_i &&
                 ((state == ST_CAL1 && cur_mode == MODE_SYS_FULL) || state == ST_CAL2);
        wr_gain = !mode_wr_i && state == ST_DIV && div_bit == 4'h0;
        run_req = mode_wr_i && mode_i != MODE_PDN && mode_i != MODE_IDLE;
    end

    // a mode write always wins, so a new request aborts whatever is running
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= ST_IDLE;
            cur_mode <= MODE_IDLE;
        end
        else if (mode_wr_i)
        begin
            cur_mode <= mode_i;
            case (mode_i)
                MODE_PDN: state <= ST_PDN;
                MODE_CONT, MODE_SINGLE: state <= ST_CONV;
                MODE_SELF_OFF, MODE_SELF_GAIN, MODE_SYS_ZERO, MODE_SYS_FULL:
                    state <= ST_CAL1;
                default: state <= ST_IDLE;
            endcase
        end
        else
        begin
            case (state)
                ST_CONV:
                    if (filter_valid_i && cur_mode == MODE_SINGLE)
                        state <= ST_IDLE;
                ST_CAL1:
                    if (filter_valid_i)
                    begin
                        if (cur_mode == MODE_SELF_GAIN)
                            state <= ST_CAL2;
                        else if (cur_mode == MODE_SYS_FULL)
                            state <= ST_DIV;
                        else
                            state <= ST_IDLE;
                    end
                ST_CAL2:
                    if (filter_valid_i)
                        state <= ST_DIV;
                ST_DIV:
                    if (div_bit == 4'h0)
                        state <= ST_IDLE;
                ST_PDN, ST_IDLE: state <= state;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // restart drops any half-settled result, so a calibration never sees it
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            filter_restart_o <= 1'b0;
        else
            filter_restart_o <= run_req || cap_zero;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            div_bit <= 4'h0;
        else if (ld_div)
            div_bit <= DIV_TOP;
        else if (state == ST_DIV && div_bit != 4'h0)
            div_bit <= div_bit - 4'h1;
    end

    always_comb
    begin
        adc_power_down_o = state == ST_PDN;
        adc_hold_reset_o = state == ST_PDN || state == ST_IDLE || state == ST_DIV;
        cal_busy_o = state == ST_CAL1 || state == ST_CAL2 || state == ST_DIV;
        // stage one of self gain sees internal zero, stage two the reference
        if (state == ST_CAL1 && (cur_mode == MODE_SELF_OFF || cur_mode == MODE_SELF_GAIN))
            input_sel_o = SEL_ZERO;
        else if (state == ST_CAL2)
            input_sel_o = SEL_REF;
        else
            input_sel_o = SEL_PINS;
    end

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        logic signed [RAW_W-1:0] raw;
        logic [OFF_W-1:0] off_coeff;
        logic [GAIN_W-1:0] gain_coeff;
        logic signed [OFF_W+17:0] off_prod;
        logic signed [RAW_W-1:0] off_align;
        logic signed [RAW_W+1:0] diff;
        logic signed [WIDE_W-1:0] scaled;
        logic signed [CORR_W-1:0] corr;
        logic over;
        logic under;
        logic signed [RAW_W-1:0] sat;
        logic [RAW_W-1:0] fmt;
        logic signed [RAW_W+2:0] off3;
        logic signed [RAW_W-1:0] zero_cap;
        logic signed [RAW_W+1:0] span;
        logic [WIDE_W-1:0] div_rem;
        logic [RAW_W+1:0] div_den;
        logic [GAIN_W-1:0] div_q;
        logic div_sat;
        logic [WIDE_W-1:0] trial;
        logic [RAW_W-1:0] res;
        logic rdy;
        logic ovr;
        logic und;

        assign raw = filter_data_i[c*RAW_W +: RAW_W];

        // stored offset is 3/4 of the real one in 24-bit format
        assign off_prod = $signed(off_coeff) * $signed({1'b0, FOUR_THIRDS});
        assign off_align = off_prod[OFF_ALIGN_SHIFT +: RAW_W];
        assign diff = $signed({{2{raw[RAW_W-1]}}, raw}) -
                      $signed({{2{off_align[RAW_W-1]}}, off_align});
        assign scaled = diff * $signed({1'b0, gain_coeff});
        assign corr = scaled[WIDE_W-1:GAIN_FRAC];
        assign over = corr > $signed({{(CORR_W-RAW_W){1'b0}}, POS_LIM});
        assign under = corr < $signed({{(CORR_W-RAW_W){1'b1}}, NEG_LIM});
        // clamp first so the unipolar shift below can never wrap
        assign sat = over ? POS_LIM : (under ? NEG_LIM : corr[RAW_W-1:0]);
        // unipolar is offset binary: negative full scale maps to zero
        assign fmt = unipolar_i ? sat - NEG_LIM : sat;

        // offset coefficient: inverse of the 4/3 and 2^5 alignment
        assign off3 = $signed({{3{raw[RAW_W-1]}}, raw}) +
                      $signed({{2{raw[RAW_W-1]}}, raw, 1'b0});

        // self gain spans reference minus captured zero; full-scale uses the offset-corrected word
        assign span = state == ST_CAL2 ?
                      $signed({{2{raw[RAW_W-1]}}, raw}) -
                      $signed({{2{zero_cap[RAW_W-1]}}, zero_cap}) : diff;
        // divisor trial moves one place right per quotient bit
        assign trial = {{(GAIN_W+1){1'b0}}, div_den} << div_bit;

        // a write lands at once; nothing guards a conversion that reads it
        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                off_coeff <= FACTORY_OFF[c*OFF_W +: OFF_W];
                gain_coeff <= FACTORY_GAIN[c*GAIN_W +: GAIN_W];
            end
            else if (coeff_wr_i && coeff_ch_i == CH_IDX_W'(c))
            begin
                if (coeff_gain_sel_i)
                    gain_coeff <= coeff_data_i[GAIN_W-1:0];
                else
                    off_coeff <= coeff_data_i;
            end
        end

        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                zero_cap <= '0;
            else if (cap_zero)
                zero_cap <= raw;
        end

        // serial divide, one quotient bit per clock, gain = full scale / span
        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                div_rem <= '0;
                div_den <= '0;
                div_q <= '0;
                div_sat <= 1'b0;
            end
            else if (ld_div)
            begin
                div_rem <= GAIN_NUMER;
                div_den <= span;
                div_q <= '0;
                // a span too small for the 16-bit coefficient saturates
                div_sat <= span[RAW_W+1] || span == '0 ||
                           {{(WIDE_W-RAW_W-GAIN_W-1){1'b0}}, span[RAW_W:0], {GAIN_W{1'b0}}}
                           <= GAIN_NUMER;
            end
            else if (state == ST_DIV && div_rem >= trial)
            begin
                div_rem <= div_rem - trial;
                div_q[div_bit] <= 1'b1;
            end
        end

        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                res <= '0;
                ovr <= 1'b0;
                und <= 1'b0;
            end
            else if (chan_en_i[c])
            begin
                if (wr_conv)
                begin
                    res <= fmt;
                    ovr <= over;
                    und <= under;
                end
                else if (wr_offcal)
                    res <= {{(RAW_W-OFF_W){off3[OFFCAL_SHIFT+OFF_W-1]}},
                            off3[OFFCAL_SHIFT +: OFF_W]};
                // last quotient bit is folded in here, saving a divide cycle
                else if (wr_gain)
                    res <= {{(RAW_W-GAIN_W){1'b0}},
                            (div_sat ? GAIN_SAT : (div_q | (trial <= div_rem ?
                            GAIN_W'(1) : {GAIN_W{1'b0}})))};
            end
        end

        // set wins over a clear in the same cycle
        // disabled channels never raise ready and keep their last result
        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                rdy <= 1'b0;
            else
                rdy <= (chan_en_i[c] && (wr_conv || wr_offcal || wr_gain)) ||
                       (rdy && !ready_clr_i[c]);
        end

        assign result_o[c*RAW_W +: RAW_W] = res;
        assign ready_o[c] = rdy;
        assign over_range_o[c] = ovr;
        assign under_range_o[c] = und;
        assign offset_coeff_o[c*OFF_W +: OFF_W] = off_coeff;
        assign gain_coeff_o[c*GAIN_W +: GAIN_W] = gain_coeff;
    end

endmodule

// >>> tb.sv
/*
 * self-checking bench for the adc calibration control block.
 * assumes default parameters: two channels, factory offset 0, gain 0x5555.
 */
`timescale 1ns/10ps
module tb;
    import adc_cal_pkg::*;
    logic clk_sys_i = 0, arst_n_i = 0, mode_wr_i = 0, unipolar_i = 0, filter_valid_i = 0;
    logic coeff_wr_i = 0, coeff_gain_sel_i = 0;
    logic [2:0] mode_i = 3'h3;
    logic [1:0] chan_en_i = 2'h1, ready_clr_i = 2'h0, input_sel_o, ready_o, over_o, under_o;
    logic [0:0] coeff_ch_i = 1'h0;
    logic [23:0] coeff_data_i = 24'h00_0000;
    logic [63:0] filter_data_i = 64'h0, result_o;
    logic [47:0] offset_coeff_o;
    logic [31:0] gain_coeff_o;
    logic restart_o, hold_o, pdn_o, busy_o;
    int num_errors = 0, check_count = 0, cycles = 0;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end

    adc_calibration_control DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .mode_wr_i(mode_wr_i), .mode_i(mode_i), .chan_en_i(chan_en_i), .unipolar_i(unipolar_i),
        .filter_valid_i(filter_valid_i), .filter_data_i(filter_data_i), .coeff_wr_i(coeff_wr_i),
        .coeff_ch_i(coeff_ch_i), .coeff_gain_sel_i(coeff_gain_sel_i),
        .coeff_data_i(coeff_data_i), .ready_clr_i(ready_clr_i), .filter_restart_o(restart_o),
        .adc_hold_reset_o(hold_o), .adc_power_down_o(pdn_o), .input_sel_o(input_sel_o),
        .cal_busy_o(busy_o), .result_o(result_o), .ready_o(ready_o), .over_range_o(over_o),
        .under_range_o(under_o), .offset_coeff_o(offset_coeff_o), .gain_coeff_o(gain_coeff_o));

    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ceiling well above the hundred or so cycles the sequence needs
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic set_mode(input logic [2:0] m);
        @(posedge clk_sys_i);
        mode_i <= m;
        mode_wr_i <= 1;
        @(posedge clk_sys_i);
        mode_wr_i <= 0;
        #1;
    endtask
    task automatic send(input logic [31:0] d0, input logic [31:0] d1);
        @(posedge clk_sys_i);
        filter_valid_i <= 1;
        filter_data_i <= {d1, d0};
        @(posedge clk_sys_i);
        filter_valid_i <= 0;
    endtask
    task automatic set_coeff(input logic ch, input logic g, input logic [23:0] d);
        @(posedge clk_sys_i);
        coeff_wr_i <= 1;
        coeff_ch_i <= ch;
        coeff_gain_sel_i <= g;
        coeff_data_i <= d;
        @(posedge clk_sys_i);
        coeff_wr_i <= 0;
    endtask
    // bounded wait; a missing ready shows up in the following compares
    task automatic wait_rdy();
        for (int i = 0; i < 60 && ready_o[0] !== 1'b1; i++)
        begin
            @(posedge clk_sys_i);
            #1;
        end
    endtask
    task automatic clr_ready();
        @(posedge clk_sys_i) ready_clr_i <= 2'h3;
        @(posedge clk_sys_i) ready_clr_i <= 2'h0;
    endtask

    task automatic test_reset();
        `CHK(offset_coeff_o, 48'h0000_0000_0000)
        `CHK(gain_coeff_o, 32'h5555_5555)
        `CHK({hold_o, ready_o}, 3'h4)
    endtask
    task automatic test_offset_cal(input logic [2:0] m, input logic [31:0] raw,
        input logic [31:0] exp, input logic [1:0] sel);
        @(posedge clk_sys_i) chan_en_i <= 2'h1;
        set_mode(m);
        `CHK({busy_o, input_sel_o}, {1'b1, sel})
        send(raw, 32'h0000_1234);
        wait_rdy();
        `CHK(result_o, {32'h0000_0000, exp})
        `CHK(offset_coeff_o, 48'h0000_0000_0000)
        `CHK({hold_o, busy_o, ready_o}, 4'h9)
        clr_ready();
    endtask
    task automatic test_gain_cal(input logic [2:0] m, input logic [31:0] raw,
        input logic [31:0] exp);
        set_mode(m);
        if (m == MODE_SELF_GAIN)
        begin
            send(32'h0000_0000, 32'h0000_0000);
            repeat (2) @(posedge clk_sys_i);
            #1;
            `CHK(input_sel_o, SEL_REF)
        end
        send(raw, 32'h0000_0000);
        wait_rdy();
        `CHK(result_o[31:0], exp)
        `CHK(gain_coeff_o, 32'h5555_5555)
        `CHK({hold_o, ready_o}, 3'h5)
        clr_ready();
    endtask
    task automatic test_convert();
        set_coeff(1'b0, 1'b0, 24'h00_0003);
        set_coeff(1'b0, 1'b1, 24'h00_4000);
        @(posedge clk_sys_i) chan_en_i <= 2'h3;
        set_mode(MODE_SINGLE);
        `CHK({offset_coeff_o, gain_coeff_o}, {48'h0000_0000_0003, 32'h5555_4000})
        send(32'h0000_1000, 32'h0000_3000);
        wait_rdy();
        `CHK(result_o[31:0], 32'h0000_0F80)
        `CHK(result_o[63:32], 32'h0000_3FFF)
        `CHK({hold_o, ready_o}, 3'h7)
        clr_ready();
    endtask
    task automatic test_clamp_abort();
        set_mode(MODE_CONT);
        send(32'h7FFF_0000, 32'h0000_0000);
        @(posedge clk_sys_i) unipolar_i <= 1;
        #1;
        `CHK({result_o[31:0], over_o[0], hold_o}, {32'h0FFF_FFFF, 2'h2})
        send(32'hC000_0000, 32'h0000_0000);
        @(posedge clk_sys_i) unipolar_i <= 0;
        #1;
        `CHK({result_o[31:0], under_o[0]}, {32'h0000_0000, 1'b1})
        set_mode(MODE_SELF_OFF);
        `CHK({busy_o, restart_o}, 2'h3)
        set_mode(MODE_IDLE);
        `CHK({hold_o, busy_o}, 2'h2)
        set_mode(MODE_PDN);
        `CHK(pdn_o, 1'b1)
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1;
        #1;
        test_reset();
        test_offset_cal(MODE_SELF_OFF, 32'h0000_0100, 32'h0000_0006, SEL_ZERO);
        test_offset_cal(MODE_SYS_ZERO, 32'hFFFF_FF00, 32'hFFFF_FFFA, SEL_PINS);
        test_gain_cal(MODE_SELF_GAIN, 32'h0800_0000, 32'h0000_7FFF);
        test_gain_cal(MODE_SYS_FULL, 32'h1000_0000, 32'h0000_3FFF);
        test_convert();
        test_clamp_abort();
        tally_and_finish();
    end
endmodule
